//--- shared/mfr_map.svh
// Offsets, field positions, reset values and timing of the fault response
`ifndef MFR_MAP_SVH
`define MFR_MAP_SVH

// Clock and 10 ms hold time
`define MFR_CLK_HZ 50000000
`define MFR_LREG_HOLD_MS 10
`define MFR_MS_PER_S 1000
`define MFR_TMR_W 20

// Register byte offsets
`define MFR_A_CTRL 8'h00
`define MFR_A_STATUS 8'h04
`define MFR_A_DIAG 8'h08
`define MFR_A_IRQ_STAT 8'h0c
`define MFR_A_IRQ_MASK 8'h10

// Control register fields
`define MFR_C_RUN 0
`define MFR_C_ESF 1
`define MFR_C_RSC 2
`define MFR_C_INH 3
`define MFR_C_LMASK 4

// Fault bit positions (status, diag, interrupt)
`define MFR_NFLT 9
`define MFR_F_SYS 0
`define MFR_F_SUP 1
`define MFR_F_LREG 2
`define MFR_F_GREG 3
`define MFR_F_BOOT 4
`define MFR_F_VDS 5
`define MFR_F_TWARN 6
`define MFR_F_OTEMP 7
`define MFR_F_SYNC 8
`define MFR_DIAG_EN 16

// Widths and reset values
`define MFR_NGATE 6
`define MFR_GATE_OFF 6'h00
`define MFR_FLT_ZERO 9'h000
`define MFR_WORD_ZERO 32'h0000_0000
`define MFR_CNT_ZERO 20'h0_0000
`define MFR_CNT_ONE 20'h0_0001

`endif

//--- shared/mfr_pkg.sv
// State types of the motor fault response block
`include "mfr_map.svh"
package mfr_pkg;

  typedef struct packed {
    logic q;
  } mfr_latch_t;

  typedef struct packed {
    logic [`MFR_TMR_W-1:0] cnt;
    logic expired;
  } mfr_timer_t;

  typedef struct packed {
    logic run;
    logic stop_on_fault_select;
    logic restart_control;
    logic inh;
    logic lmask;
    logic [`MFR_NFLT-1:0] irq_stat;
    logic [`MFR_NFLT-1:0] irq_mask;
    logic [`MFR_NFLT-1:0] cond_prev;
    logic [`MFR_NGATE-1:0] pwm_prev;
    logic [`MFR_NGATE-1:0] blk;
    logic lockout;
    logic sys_lock;
    logic sys_seen;
    logic dz_prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [`MFR_NGATE-1:0] gate;
    logic irq;
    logic host_rst_n;
    logic restart;
  } mfr_state_t;

endpackage : mfr_pkg

//--- design/mfr_latch.sv
// Sticky fault state cell, set wins over clear
`timescale 1ns/1ps
module mfr_latch
  import mfr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Set and clear
  input wire logic set_in,
  input wire logic clr_in,
  // Latched state
  output logic q
);

  mfr_latch_t s_r;
  mfr_latch_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (set_in) begin
      s_nxt.q = 1'b1;
    end else if (clr_in) begin
      s_nxt.q = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;

endmodule : mfr_latch

//--- design/mfr_timer.sv
// Hold-off counter, expires after a set number of armed cycles
`timescale 1ns/1ps
module mfr_timer
  import mfr_pkg::*;
#(
  parameter logic [`MFR_TMR_W-1:0] CYC = `MFR_CNT_ONE
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Count while armed, restart when not
  input wire logic arm,
  // High from the last counted cycle while still armed
  output logic expired
);

  mfr_timer_t s_r;
  mfr_timer_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!arm) begin
      s_nxt.cnt = `MFR_CNT_ZERO;
      s_nxt.expired = 1'b0;
    end else if (s_r.cnt == CYC - `MFR_CNT_ONE) begin
      s_nxt.expired = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + `MFR_CNT_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expired = s_r.expired;

endmodule : mfr_timer

//--- design/mfr_top.sv
// Fault response policy with APB registers and interrupt
// What this block does
// - All-off fault drives all six gates low
// - Stop-on-fault: bootstrap/DRAIN_SOURCE_VOLTAGE fault gates one transistor
// - Logic regulator undervoltage latches, resets host, 10ms
// - Stop-on-fault supply undervoltage keeps outputs, latch per restart
// - Sync loss latches off, or restarts automatically
// - Status or diag read clears supply, bootstrap/VDS, temperature and sync latches unless inhibited
// - Restart control picks latch or auto recovery
// - Stop-on-fault with lmask set: temperature faults show in diag and interrupt status only, not latched in status
// - Without stop-on-fault supply undervoltage disables all
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module mfr_top
  import mfr_pkg::*;
#(
  parameter int unsigned LREG_HOLD_CYC =
    `MFR_LREG_HOLD_MS * (`MFR_CLK_HZ / `MFR_MS_PER_S)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fault conditions, high while present
  input wire logic sys_err_in,
  input wire logic main_supply_uv,
  input wire logic logic_regulator_uv,
  input wire logic gate_drive_regulator_uv,
  input wire logic [`MFR_NGATE-1:0] boot_uv,
  input wire logic [`MFR_NGATE-1:0] drain_source_voltage_ov,
  input wire logic temp_warn,
  input wire logic over_temp,
  input wire logic sync_lost,
  // Demand and PWM commands
  input wire logic demand_zero,
  input wire logic [`MFR_NGATE-1:0] pwm_cmd,
  // Gate drives and host side
  output logic [`MFR_NGATE-1:0] gate_drv,
  output logic host_reset_out_n,
  output logic restart_req,
  output logic irq
);

  mfr_state_t s_r;
  mfr_state_t s_nxt;

  logic [`MFR_NFLT-1:0] cond;
  logic [`MFR_NFLT-1:0] latched;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic serial_clr;
  logic clr_any;
  logic lreg_expired;
  logic l_sup;
  logic l_bv;
  logic l_ot;
  logic l_ls;
  logic l_lr;
  logic bv_any;
  logic ot_set;
  logic latched_dis;
  logic disable_all;
  logic demand_rearm;
  logic run_rise;
  logic [`MFR_NGATE-1:0] pwm_rise;
  logic [`MFR_NGATE-1:0] blk_cond;

  // Live condition vector
  always_comb begin
    cond = `MFR_FLT_ZERO;
    cond[`MFR_F_SYS] = sys_err_in;
    cond[`MFR_F_SUP] = main_supply_uv;
    cond[`MFR_F_LREG] = logic_regulator_uv;
    cond[`MFR_F_GREG] = gate_drive_regulator_uv;
    cond[`MFR_F_BOOT] = |boot_uv;
    cond[`MFR_F_VDS] = |drain_source_voltage_ov;
    cond[`MFR_F_TWARN] = temp_warn;
    cond[`MFR_F_OTEMP] = over_temp;
    cond[`MFR_F_SYNC] = sync_lost;
  end

  assign acc_done = psel & penable & s_r.pready;
  assign wr_done = acc_done & pwrite;
  assign rd_done = acc_done & ~pwrite;

  assign serial_clr = rd_done & ~s_r.inh &
    ((paddr == `MFR_A_STATUS) | (paddr == `MFR_A_DIAG));

  // demand zero, run zero or read clear
  assign clr_any = demand_zero | ~s_r.run | serial_clr;

  assign bv_any = cond[`MFR_F_BOOT] | cond[`MFR_F_VDS];

  assign ot_set = over_temp & ~(s_r.stop_on_fault_select & s_r.lmask);

  mfr_latch u_sup (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(main_supply_uv & ~s_r.restart_control),
    .clr_in(clr_any),
    .q(l_sup)
  );

  mfr_latch u_bv (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(bv_any & ~s_r.stop_on_fault_select),
    .clr_in(clr_any),
    .q(l_bv)
  );

  mfr_latch u_ot (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(ot_set),
    .clr_in(clr_any),
    .q(l_ot)
  );

  // sync loss latches under restart control 0
  mfr_latch u_ls (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(sync_lost & ~s_r.restart_control),
    .clr_in(clr_any),
    .q(l_ls)
  );

  mfr_latch u_lr (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(logic_regulator_uv),
    .clr_in(lreg_expired),
    .q(l_lr)
  );

  mfr_timer #(
    .CYC(LREG_HOLD_CYC[`MFR_TMR_W-1:0])
  ) u_lreg_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .arm(l_lr & ~logic_regulator_uv),
    .expired(lreg_expired)
  );

  always_comb begin
    latched = `MFR_FLT_ZERO;
    latched[`MFR_F_SYS] = s_r.sys_seen;
    latched[`MFR_F_SUP] = l_sup;
    latched[`MFR_F_LREG] = l_lr;
    latched[`MFR_F_BOOT] = l_bv;
    latched[`MFR_F_VDS] = l_bv;
    latched[`MFR_F_OTEMP] = l_ot;
    latched[`MFR_F_SYNC] = l_ls;
  end

  assign latched_dis = l_bv | l_ot | l_ls | l_lr | (l_sup & ~s_r.stop_on_fault_select);

  assign demand_rearm = s_r.dz_prev & ~demand_zero;
  assign run_rise = wr_done & (paddr == `MFR_A_CTRL) & ~s_r.run &
    pwdata[`MFR_C_RUN];

  assign disable_all = s_r.sys_lock | latched_dis | s_r.lockout |
    gate_drive_regulator_uv | (sync_lost & s_r.restart_control) |
    (main_supply_uv & ~s_r.stop_on_fault_select);

  assign pwm_rise = pwm_cmd & ~s_r.pwm_prev;
  assign blk_cond = (boot_uv | drain_source_voltage_ov) &
    {`MFR_NGATE{s_r.stop_on_fault_select}};

  always_comb begin
    s_nxt = s_r;
    s_nxt.cond_prev = cond;
    s_nxt.pwm_prev = pwm_cmd;
    s_nxt.dz_prev = demand_zero;

    // APB access: one wait state, then answer
    s_nxt.pready = psel & penable & ~s_r.pready;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = `MFR_WORD_ZERO;
    if (psel & penable & ~s_r.pready) begin
      case (paddr)
        `MFR_A_CTRL: begin
          s_nxt.prdata[`MFR_C_RUN] = s_r.run;
          s_nxt.prdata[`MFR_C_ESF] = s_r.stop_on_fault_select;
          s_nxt.prdata[`MFR_C_RSC] = s_r.restart_control;
          s_nxt.prdata[`MFR_C_INH] = s_r.inh;
          s_nxt.prdata[`MFR_C_LMASK] = s_r.lmask;
        end
        `MFR_A_STATUS: begin
          s_nxt.prdata[`MFR_NFLT-1:0] = latched;
        end
        `MFR_A_DIAG: begin
          s_nxt.prdata[`MFR_NFLT-1:0] = cond;
          s_nxt.prdata[`MFR_DIAG_EN] = ~disable_all;
        end
        `MFR_A_IRQ_STAT: begin
          s_nxt.prdata[`MFR_NFLT-1:0] = s_r.irq_stat;
        end
        `MFR_A_IRQ_MASK: begin
          s_nxt.prdata[`MFR_NFLT-1:0] = s_r.irq_mask;
        end
        default: begin
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end

    // Register writes
    if (wr_done) begin
      case (paddr)
        `MFR_A_CTRL: begin
          s_nxt.run = pwdata[`MFR_C_RUN];
          s_nxt.stop_on_fault_select = pwdata[`MFR_C_ESF];
          s_nxt.restart_control = pwdata[`MFR_C_RSC];
          s_nxt.inh = pwdata[`MFR_C_INH];
          s_nxt.lmask = pwdata[`MFR_C_LMASK];
        end
        `MFR_A_IRQ_STAT: begin
          s_nxt.irq_stat = s_r.irq_stat & ~pwdata[`MFR_NFLT-1:0];
        end
        `MFR_A_IRQ_MASK: begin
          s_nxt.irq_mask = pwdata[`MFR_NFLT-1:0];
        end
        default: begin
        end
      endcase
    end

    // Fault onset sets sticky bits, set wins over clear
    s_nxt.irq_stat = s_nxt.irq_stat | (cond & ~s_r.cond_prev);

    // system error forces run low and holds off
    if (sys_err_in) begin
      s_nxt.run = 1'b0;
      s_nxt.sys_lock = 1'b1;
      s_nxt.sys_seen = 1'b1;
    end else if (run_rise) begin
      s_nxt.sys_lock = 1'b0;
    end

    // lockout held until host restarts the demand or run, or reads status/diag
    if (latched_dis) begin
      s_nxt.lockout = 1'b1;
    end else if (demand_rearm | run_rise | serial_clr) begin
      s_nxt.lockout = 1'b0;
    end

    s_nxt.blk = (s_r.blk & ~pwm_rise) | blk_cond;

    if (disable_all) begin
      s_nxt.gate = `MFR_GATE_OFF;
    end else begin
      s_nxt.gate = pwm_cmd & ~s_nxt.blk;
    end

    // host reset low while regulator latch holds
    s_nxt.host_rst_n = ~(logic_regulator_uv | l_lr);

    // auto restart pulse on sync loss
    s_nxt.restart = s_r.restart_control & sync_lost & ~s_r.cond_prev[`MFR_F_SYNC];

    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.host_rst_n <= 1'b0;
      s_r.dz_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign gate_drv = s_r.gate;
  assign host_reset_out_n = s_r.host_rst_n;
  assign restart_req = s_r.restart;
  assign irq = s_r.irq;

endmodule : mfr_top

//--- tb/mfr_props.sv
// Port checker for the motor fault response block
`timescale 1ns/1ps
`include "mfr_map.svh"
module mfr_props
  import mfr_pkg::*;
#(
  parameter int unsigned LREG_HOLD_CYC = 20
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched ports
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sys_err_in,
  input wire logic logic_regulator_uv,
  input wire logic gate_drive_regulator_uv,
  input wire logic sync_lost,
  input wire logic [`MFR_NGATE-1:0] boot_uv,
  input wire logic [`MFR_NGATE-1:0] pwm_cmd,
  input wire logic [`MFR_NGATE-1:0] gate_drv,
  input wire logic host_reset_out_n,
  input wire logic restart_req
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  greg_all_off_a: assert property (
    gate_drive_regulator_uv [*3] |-> gate_drv == 6'h00)
    else $error("drives on in regulator fault");
  sys_all_off_a: assert property (
    sys_err_in [*3] |-> gate_drv == 6'h00)
    else $error("drives on in system error");
  lreg_off_a: assert property (
    logic_regulator_uv [*3] |-> gate_drv == 6'h00 && !host_reset_out_n)
    else $error("logic regulator fault not acted on");
  host_hold_a: assert property (
    $fell(logic_regulator_uv) |-> !host_reset_out_n [*8])
    else $error("host reset released early");
  host_rise_a: assert property (
    $rose(host_reset_out_n) |-> !$past(logic_regulator_uv))
    else $error("host reset released in fault");
  boot_gate_off_a: assert property (
    boot_uv != 6'h00 ##1 $stable(boot_uv) [*2]
      |-> (gate_drv & boot_uv) == 6'h00)
    else $error("blocked gate still driven");
  gate_follow_a: assert property (
    (gate_drv & ~$past(pwm_cmd)) == 6'h00)
    else $error("gate driven without command");
  restart_cause_a: assert property (
    restart_req |-> $past(sync_lost) || $past(sync_lost, 2))
    else $error("restart without sync loss");
  pready_pulse_a: assert property (
    pready |=> !pready)
    else $error("pready longer than one cycle");
  cover property ($rose(host_reset_out_n));
  cover property (restart_req);
  cover property (pslverr);
endmodule : mfr_props

bind mfr_top mfr_props #(.LREG_HOLD_CYC(LREG_HOLD_CYC)) props_u (
  .pclk(pclk), .presetn(presetn), .pready(pready), .pslverr(pslverr),
  .sys_err_in(sys_err_in), .logic_regulator_uv(logic_regulator_uv),
  .gate_drive_regulator_uv(gate_drive_regulator_uv),
  .sync_lost(sync_lost), .boot_uv(boot_uv), .pwm_cmd(pwm_cmd),
  .gate_drv(gate_drv), .host_reset_out_n(host_reset_out_n),
  .restart_req(restart_req)
);

//--- tb/mfr_host.sv
// Host model driving the demand input
`timescale 1ns/1ps
module mfr_host (
  // Clock and request
  input wire logic pclk,
  input wire logic go,
  // High while demand is zero
  output logic demand_zero
);
  logic [1:0] cnt_r;
  initial begin
    cnt_r = 2'h0;
    demand_zero = 1'h0;
  end
  always @(posedge pclk) begin
    if (go) begin
      demand_zero <= 1'h1;
      cnt_r <= 2'h2;
    end else if (cnt_r != 2'h0) begin
      cnt_r <= cnt_r - 2'h1;
      if (cnt_r == 2'h1) demand_zero <= 1'h0;
    end
  end
endmodule : mfr_host

//--- tb/tb_top.sv
// Self-checking bench for the motor fault response block
`timescale 1ns/1ps
module tb_top;
  import mfr_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic go = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [8:0] cond = 9'h000;
  logic [5:0] bv = 6'h00;
  logic [5:0] pwm = 6'h3f;
  logic [31:0] prdata, rd;
  logic [5:0] gate_drv;
  logic pready, pslverr, err, irq, hrst_n, rreq, dz;
  int mismatches = 0;
  int n_checks = 0;
  always #10 pclk = ~pclk;
  mfr_top #(.LREG_HOLD_CYC(20)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sys_err_in(cond[0]),
    .main_supply_uv(cond[1]), .logic_regulator_uv(cond[2]),
    .gate_drive_regulator_uv(cond[3]), .boot_uv(bv),
    .drain_source_voltage_ov({5'h00, cond[5]}), .temp_warn(cond[6]),
    .over_temp(cond[7]), .sync_lost(cond[8]), .demand_zero(dz),
    .pwm_cmd(pwm), .gate_drv(gate_drv), .host_reset_out_n(hrst_n),
    .restart_req(rreq), .irq(irq));
  mfr_host host_u (.pclk(pclk), .go(go), .demand_zero(dz));
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic gate_is(input logic [5:0] e);
    chk(32'(gate_drv), 32'(e));
  endtask : gate_is
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'h1 && t < 50);
    if (t >= 50) begin
      mismatches++;
      $display("[ERR] %0t apb transfer timed out", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic ctl(input logic [31:0] d);
    apb(1'h1, 8'h00, d);
  endtask : ctl
  task automatic stat;
    apb(1'h0, 8'h04, 32'h0);
  endtask : stat
  task automatic pulse(input int b, input logic [5:0] e);
    cond[b] <= 1'h1;
    cyc(3);
    gate_is(e);
    cond[b] <= 1'h0;
    cyc(3);
  endtask : pulse
  task automatic print_verdict;
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  initial begin
    cyc(3);
    presetn <= 1'h1;
    cyc(3);
    chk(32'(hrst_n), 32'h1);
    ctl(32'h3);
    bv <= 6'h04;
    cond[5] <= 1'h1;
    cyc(3);
    gate_is(6'h3a);
    bv <= 6'h00;
    cond[5] <= 1'h0;
    cyc(3);
    gate_is(6'h3a);
    pwm <= 6'h3a;
    cyc(1);
    pwm <= 6'h3f;
    cyc(3);
    gate_is(6'h3f);
    pulse(3, 6'h00);
    gate_is(6'h3f);
    ctl(32'hb);
    pulse(1, 6'h3f);
    stat();
    stat();
    chk(rd, 32'h2);
    ctl(32'h3);
    stat();
    stat();
    chk(rd, 32'h0);
    ctl(32'h1);
    pulse(8, 6'h00);
    gate_is(6'h00);
    go <= 1'h1;
    cyc(1);
    go <= 1'h0;
    cyc(6);
    gate_is(6'h3f);
    ctl(32'h5);
    rd = 32'h0;
    cond[8] <= 1'h1;
    repeat (4) begin
      @(posedge pclk);
      rd[0] = rd[0] | rreq;
    end
    chk(rd, 32'h1);
    cond[8] <= 1'h0;
    cyc(3);
    gate_is(6'h3f);
    ctl(32'h1);
    pulse(1, 6'h00);
    gate_is(6'h00);
    ctl(32'h0);
    ctl(32'h1);
    cyc(2);
    gate_is(6'h3f);
    ctl(32'h13);
    pulse(6, 6'h3f);
    pulse(7, 6'h3f);
    stat();
    chk(rd, 32'h0);
    ctl(32'h1);
    cond[2] <= 1'h1;
    cyc(3);
    gate_is(6'h00);
    cond[2] <= 1'h0;
    cyc(10);
    chk(32'(hrst_n), 32'h0);
    cyc(20);
    chk(32'(hrst_n), 32'h1);
    stat();
    cyc(2);
    gate_is(6'h3f);
    apb(1'h1, 8'h0c, 32'h1ff);
    apb(1'h1, 8'h10, 32'h2);
    pulse(1, 6'h00);
    chk(32'(irq), 32'h1);
    apb(1'h1, 8'h10, 32'h0);
    cyc(2);
    chk(32'(irq), 32'h0);
    apb(1'h1, 8'h10, 32'h2);
    cyc(2);
    chk(32'(irq), 32'h1);
    apb(1'h1, 8'h0c, 32'h2);
    cyc(2);
    chk(32'(irq), 32'h0);
    apb(1'h0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    pulse(0, 6'h00);
    apb(1'h0, 8'h00, 32'h0);
    chk(32'(rd[0]), 32'h0);
    ctl(32'h1);
    cyc(2);
    gate_is(6'h3f);
    apb(1'h0, 8'h0c, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, 8'h08, 32'h0);
    chk(rd, 32'h0001_0000);
    print_verdict();
  end
endmodule : tb_top
